// [core/hub_sideband_ctl.sv]
// Sideband control, indicator and strap logic of the seven-port hub
// Overview of operation
// - Ganged mode: common control drives all enabled ports
// - Swap input low: port 0 upstream
// - Swap input high: port 1 upstream
// - Swap state output shows current role
// - ROM select held high in power-down
// - ROM disable bit frees clock pin
// - ROM clock held low during reset unless ROM disable bit set
// - Attach input powers matching SuperSpeed PHY
// - Speed flag: float, 0 slow, 1 SuperSpeed
// - Charge flag: float, 0 handshake, 1 none
// - Suspend flag reflects USB 2.0 suspend
// - External reset low holds reset mode
// - Straps captured at every reset release
// - Both disable straps judged per port
// - Mode strap sets indicator and management
// - Management interface only ever a target
// - Fixed-port strap sets non-removable count
// - Charge strap sets charging port count
// - Port off only when both straps high
// - Modes one/two speed, five charge flags
// - Enabled port senses, disabled drives low
`timescale 1ns/100ps
module hub_sideband_ctl
	import hub_sideband_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic por_n,
	input wire logic reset_pin_n,
	input wire logic role_swap_cmd,
	input wire logic common_port_power_ctl,
	input wire logic ganged_mode,
	input wire logic [3:0] type_c_attach,
	input wire strap_s strap_pins,
	input wire port_status_s port_status,
	input wire logic [6:0] port_power_wanted,
	input wire logic [7:0] port_power_ctl_in,
	input wire logic utility_config_one_rom_off,
	input wire logic rom_cs_run_n,
	input wire logic rom_clk_run,
	input wire logic power_down,
	input wire logic usb2_suspend,
	input wire logic general_io_four_out,
	input wire logic general_io_four_oe_n,
	output logic role_swap_state,
	output logic [7:0] port_power_ctl_out,
	output logic [7:0] port_power_ctl_oe_n,
	output logic [7:0] port_overcurrent,
	output logic [3:0] ss_phy_on,
	output logic [6:0] link_speed_flag,
	output logic [6:0] link_speed_flag_oe_n,
	output logic [6:0] charge_status_flag,
	output logic [6:0] charge_status_flag_oe_n,
	output logic suspend_flag,
	output logic rom_cs_n,
	output logic rom_clk,
	output logic rom_clk_oe_n,
	output logic general_io_four_in,
	output logic in_reset,
	output logic mgmt_enable,
	output logic mgmt_target,
	output logic [6:0] port_disabled,
	output logic [6:0] port_fixed,
	output logic [6:0] port_charge_en
);

	////////////////////////////////////////////////////////////////
	// Helpers

	// Thermometer mask of ports 1 upward from a count code
	function automatic logic [6:0] count_mask(input logic [2:0] code);
		logic [6:0] m;
		m = PORTS_NONE;
		unique case (code)
			CNT_NONE: m = PORTS_NONE;
			CNT_ONE: m = 7'h01;
			CNT_TWO: m = 7'h03;
			CNT_THREE: m = 7'h07;
			CNT_FOUR: m = 7'h0f;
			CNT_ALL: m = PORTS_ALL;
			default: m = PORTS_NONE;
		endcase
		return m;
	endfunction

	// Three-stage synchroniser step: shift in a new sample
	function automatic logic [2:0] sync_shift(input logic [2:0] s,
		input logic d);
		return {s[1:0], d};
	endfunction

	////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [2:0] swap_sync;
	logic [2:0] gang_sync;
	logic [2:0] rstpin_sync;
	logic [2:0] attach_sync [NUM_ATTACH];
	logic [2:0] pctl_sync [8];
	logic swap_lvl;
	logic gang_lvl;
	logic rstpin_lvl;
	logic [3:0] attach_lvl;
	logic [7:0] pctl_lvl;

	// Sample the swap, ganged control and reset pins into their shift chains
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			swap_sync <= 3'h0;
			gang_sync <= 3'h0;
			rstpin_sync <= 3'h0;
		end
		else
		begin
			swap_sync <= sync_shift(swap_sync, role_swap_cmd);
			gang_sync <= sync_shift(gang_sync, common_port_power_ctl);
			rstpin_sync <= sync_shift(rstpin_sync, reset_pin_n);
		end
	end

	// Attach and port control pin chains
	always_ff @(posedge clk_sys)
	begin
		for (int i = 0; i < NUM_ATTACH; i++)
		begin
			if (!rst_n)
				attach_sync[i] <= 3'h0;
			else
				attach_sync[i] <= sync_shift(attach_sync[i], type_c_attach[i]);
		end
		for (int j = 0; j < 8; j++)
		begin
			if (!rst_n)
				pctl_sync[j] <= 3'h7;
			else
				pctl_sync[j] <= sync_shift(pctl_sync[j], port_power_ctl_in[j]);
		end
	end

	// Filtered levels: change once stages two and three agree
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			swap_lvl <= 1'b0;
			gang_lvl <= 1'b0;
			rstpin_lvl <= 1'b0;
			attach_lvl <= 4'h0;
			pctl_lvl <= 8'hff;
		end
		else
		begin
			if (swap_sync[1] == swap_sync[2])
				swap_lvl <= swap_sync[2];
			if (gang_sync[1] == gang_sync[2])
				gang_lvl <= gang_sync[2];
			if (rstpin_sync[1] == rstpin_sync[2])
				rstpin_lvl <= rstpin_sync[2];
			for (int i = 0; i < NUM_ATTACH; i++)
				if (attach_sync[i][1] == attach_sync[i][2])
					attach_lvl[i] <= attach_sync[i][2];
			for (int j = 0; j < 8; j++)
				if (pctl_sync[j][1] == pctl_sync[j][2])
					pctl_lvl[j] <= pctl_sync[j][2];
		end
	end

	////////////////////////////////////////////////////////////////
	// Reset mode and strap capture

	life_e life;
	logic por_seen;
	strap_s straps;

	// Reset mode while any of rst_n, por_n or the filtered reset pin is low
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n || !por_n || !rstpin_lvl)
			life <= ST_RESET;
		else
		begin
			unique case (life)
				ST_RESET: life <= ST_CAPTURE;
				ST_CAPTURE: life <= ST_RUN;
				ST_RUN: life <= ST_RUN;
				default: life <= ST_RESET;
			endcase
		end
	end

	// Latch straps on the capture step only
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			straps.mode <= MODE_RESET;
			straps.dp_off <= PORTS_NONE;
			straps.dm_off <= PORTS_NONE;
			straps.fixed_cnt <= CNT_RESET;
			straps.charge_cnt <= CNT_RESET;
			por_seen <= 1'b0;
		end
		else
		begin
			por_seen <= 1'b1;
			if (life == ST_CAPTURE)
				straps <= strap_pins;
		end
	end

	////////////////////////////////////////////////////////////////
	// Strap decode

	logic [6:0] next_port_disabled;
	logic [6:0] next_fixed;
	logic [6:0] next_charge;
	logic speed_mode;
	logic charge_mode;

	// Port and count decode from captured straps
	always_comb
	begin
		next_port_disabled = straps.dp_off & straps.dm_off;
		next_fixed = count_mask(straps.fixed_cnt);
		next_charge = count_mask(straps.charge_cnt);
		speed_mode = (straps.mode == MODE_SPEED_NO_MGMT) ||
			(straps.mode == MODE_SPEED_TARGET);
		charge_mode = (straps.mode == MODE_CHARGE_IND);
	end

	// Registered configuration outputs
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			port_disabled <= PORTS_NONE;
			port_fixed <= PORTS_NONE;
			port_charge_en <= PORTS_NONE;
			mgmt_enable <= 1'b0;
			mgmt_target <= 1'b0;
			in_reset <= 1'b1;
		end
		else
		begin
			port_disabled <= next_port_disabled;
			port_fixed <= next_fixed;
			port_charge_en <= next_charge;
			mgmt_enable <= (straps.mode == MODE_SPEED_TARGET);
			mgmt_target <= (straps.mode == MODE_SPEED_TARGET);
			in_reset <= (life != ST_RUN) || !por_seen;
		end
	end

	////////////////////////////////////////////////////////////////
	// Role swap and port power

	// Upstream role follows the swap command
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			role_swap_state <= 1'b0;
		else if (life == ST_RUN)
			role_swap_state <= swap_lvl;
	end

	logic [7:0] next_pwr_on;
	logic [7:0] next_port_en;

	// Power wish per port; port 0 only when it is downstream
	always_comb
	begin
		next_port_en = {~port_disabled & ~port_status.host_port_off,
			role_swap_state};
		if (ganged_mode)
			next_pwr_on = {8{gang_lvl}};
		else
			next_pwr_on = {port_power_wanted, 1'b1};
		next_pwr_on = next_pwr_on & next_port_en;
	end

	// Enabled pin released to its pull-up, disabled pin driven low
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			port_power_ctl_out <= 8'h00;
			port_power_ctl_oe_n <= 8'hff;
			port_overcurrent <= 8'h00;
		end
		else
		begin
			port_power_ctl_out <= 8'h00;
			port_power_ctl_oe_n <= next_pwr_on;
			port_overcurrent <= next_pwr_on & ~pctl_lvl;
		end
	end

	////////////////////////////////////////////////////////////////
	// PHY enables and indicators

	// SuperSpeed PHY on while attach input high
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			ss_phy_on <= 4'h0;
		else
			ss_phy_on <= attach_lvl & {4{life == ST_RUN}};
	end

	// Speed and charge flags, floating when not applicable
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			link_speed_flag <= PORTS_NONE;
			link_speed_flag_oe_n <= PORTS_ALL;
			charge_status_flag <= PORTS_NONE;
			charge_status_flag_oe_n <= PORTS_ALL;
		end
		else
		begin
			link_speed_flag <= port_status.superspeed;
			link_speed_flag_oe_n <= ~(port_status.connected &
				{7{speed_mode}});
			charge_status_flag <= ~port_status.bc_handshake;
			charge_status_flag_oe_n <= ~(next_charge &
				{7{charge_mode}});
		end
	end

	// Suspend indicator for host wakeup sideband
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			suspend_flag <= 1'b0;
		else
			suspend_flag <= usb2_suspend && (life == ST_RUN);
	end

	////////////////////////////////////////////////////////////////
	// Serial ROM pins

	// Chip select high in power-down; clock low in reset unless freed
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			rom_cs_n <= 1'b1;
			rom_clk <= 1'b0;
			rom_clk_oe_n <= 1'b0;
			general_io_four_in <= 1'b0;
		end
		else
		begin
			general_io_four_in <= rom_clk_run;
			if (utility_config_one_rom_off)
			begin
				rom_cs_n <= 1'b1;
				rom_clk <= general_io_four_out;
				rom_clk_oe_n <= general_io_four_oe_n;
			end
			else
			begin
				rom_cs_n <= power_down || rom_cs_run_n || in_reset;
				rom_clk <= rom_clk_run && !in_reset && (life == ST_RUN);
				rom_clk_oe_n <= 1'b0;
			end
		end
	end

endmodule

// [core/hub_sideband_pkg.sv]
// Shared constants and carrier types for the hub sideband pin block
package hub_sideband_pkg;

	localparam int NUM_DN = 7;
	localparam int NUM_ATTACH = 4;
	localparam int SYNC_DEPTH = 3;

	// Mode strap encodings, one code per strap setting
	localparam logic [2:0] MODE_SPEED_NO_MGMT = 3'h0;
	localparam logic [2:0] MODE_SPEED_TARGET = 3'h1;
	localparam logic [2:0] MODE_RSVD_THREE = 3'h2;
	localparam logic [2:0] MODE_RSVD_FOUR = 3'h3;
	localparam logic [2:0] MODE_CHARGE_IND = 3'h4;
	localparam logic [2:0] MODE_RSVD_SIX = 3'h5;

	// Port-count strap encodings: number of ports from port 1 upward
	localparam logic [2:0] CNT_NONE = 3'h0;
	localparam logic [2:0] CNT_ONE = 3'h1;
	localparam logic [2:0] CNT_TWO = 3'h2;
	localparam logic [2:0] CNT_THREE = 3'h3;
	localparam logic [2:0] CNT_FOUR = 3'h4;
	localparam logic [2:0] CNT_ALL = 3'h5;

	// Reset values of captured straps
	localparam logic [2:0] MODE_RESET = MODE_SPEED_NO_MGMT;
	localparam logic [2:0] CNT_RESET = CNT_NONE;
	localparam logic [6:0] PORTS_NONE = 7'h00;
	localparam logic [6:0] PORTS_ALL = 7'h7f;

	// Strap pin bundle
	typedef struct packed {
		logic [2:0] mode;
		logic [6:0] dp_off;
		logic [6:0] dm_off;
		logic [2:0] fixed_cnt;
		logic [2:0] charge_cnt;
	} strap_s;

	// Per-port link status from the hub core
	typedef struct packed {
		logic [6:0] connected;
		logic [6:0] superspeed;
		logic [6:0] bc_handshake;
		logic [6:0] host_port_off;
	} port_status_s;

	// Hub life cycle, Gray along reset -> capture -> run
	typedef enum logic [1:0] {
		ST_RESET = 2'b00,
		ST_CAPTURE = 2'b01,
		ST_RUN = 2'b11
	} life_e;

endpackage

// [tb/hub_sideband_board.sv]
// Board side: attach sources and pulled-up power switch pins
`timescale 1ns/100ps
module hub_sideband_board
(
	input wire logic legacy_board,
	input wire logic [3:0] attach_req,
	input wire logic [7:0] fault,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe_n,
	output logic [3:0] type_c_attach,
	output logic [7:0] port_power_ctl_in
);
	// Legacy connectors tie every attach line high
	assign type_c_attach = legacy_board ? 4'hf : attach_req;
	// Pull-up when released, low on switch fault, pin_out when driven
	assign port_power_ctl_in = (pin_oe_n & ~fault) | (~pin_oe_n & pin_out);
endmodule

// [tb/hub_sideband_ctl_tb.sv]
// Self-checking bench for the sideband pin block
`timescale 1ns/100ps
module hub_sideband_ctl_tb
	import hub_sideband_pkg::*;
;
	logic clk_sys;
	logic rst_n = 1'b0, por_n = 1'b1, reset_pin_n = 1'b1, role_swap_cmd = 1'b0;
	logic common_port_power_ctl = 1'b0, ganged_mode = 1'b0, power_down = 1'b0;
	logic utility_config_one_rom_off = 1'b0, usb2_suspend = 1'b0;
	logic rom_cs_run_n = 1'b1, rom_clk_run = 1'b0, legacy_board = 1'b0;
	logic general_io_four_out = 1'b0, general_io_four_oe_n = 1'b1;
	logic [3:0] attach_req = 4'h0;
	logic [7:0] fault = 8'h00;
	logic [6:0] port_power_wanted = 7'h00;
	strap_s strap_pins = '0;
	port_status_s port_status = '0;
	logic [3:0] type_c_attach, ss_phy_on;
	logic [7:0] port_power_ctl_in, port_power_ctl_out, port_power_ctl_oe_n;
	logic [7:0] port_overcurrent;
	logic [6:0] link_speed_flag, link_speed_flag_oe_n, charge_status_flag;
	logic [6:0] charge_status_flag_oe_n, port_disabled, port_fixed;
	logic [6:0] port_charge_en;
	logic role_swap_state, suspend_flag, rom_cs_n, rom_clk, rom_clk_oe_n;
	logic general_io_four_in, in_reset, mgmt_enable, mgmt_target;
	int n_errors = 0;
	int tests_run = 0;
	int c;

	hub_sideband_ctl uut (.*);
	hub_sideband_board board (.legacy_board(legacy_board),
		.attach_req(attach_req), .fault(fault),
		.pin_out(port_power_ctl_out), .pin_oe_n(port_power_ctl_oe_n),
		.type_c_attach(type_c_attach), .port_power_ctl_in(port_power_ctl_in));

	////////////////////////////////////////////////////////////////////////
	// Clock at 20 MHz
	initial
	begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	// Compare and count
	task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
		tests_run++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic settle;
		repeat (8) @(negedge clk_sys);
	endtask

	// Reset pin cycle with new straps, then wait for run mode
	task automatic pin_reset(strap_s s);
		int i;
		strap_pins = s;
		reset_pin_n = 1'b0;
		settle();
		chk("in_reset", 8'h01, in_reset);
		chk("rom_clk", 8'h00, {rom_clk, rom_clk_oe_n});
		reset_pin_n = 1'b1;
		for (i = 0; i < 20 && in_reset !== 1'b0; i++)
			@(negedge clk_sys);
		chk("run", 8'h00, in_reset);
		settle();
	endtask

	function automatic logic [6:0] span(int n);
		return (n == 5) ? 7'h7f : 7'((8'h01 << n) - 8'h01);
	endfunction

	task automatic report_and_stop;
		$display("errors %0d of %0d checks", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Watchdog
	initial
	begin
		repeat (5000) @(posedge clk_sys);
		n_errors++;
		report_and_stop();
	end

	// Test sequence
	initial
	begin
		repeat (16) @(negedge clk_sys);
		rst_n = 1'b1;
		for (c = 0; c < 6; c++)
		begin
			pin_reset('{3'(c), 7'h41, 7'h43, 3'(c), 3'(5 - c)});
			chk("disabled", 8'h41, port_disabled);
			chk("fixed", span(c), port_fixed);
			chk("charge_en", span(5 - c), port_charge_en);
			if (c < 2)
				chk("mgmt", 8'(c), mgmt_enable);
		end
		strap_pins = '1;
		settle();
		chk("held", 8'h41, port_disabled);
		pin_reset('{MODE_SPEED_TARGET, PORTS_NONE, PORTS_NONE, CNT_NONE, CNT_TWO});
		chk("target", 8'h01, mgmt_target);
		port_status = '{7'h0f, 7'h05, 7'h01, 7'h00};
		settle();
		chk("speed_oe", 8'h70, link_speed_flag_oe_n);
		chk("speed", 8'h05, link_speed_flag & 7'h0f);
		for (c = 0; c < 2; c++)
		begin
			role_swap_cmd = 1'(c);
			settle();
			chk("swap", 8'(c), role_swap_state);
			chk("port0", 8'(c), port_power_ctl_oe_n[0]);
		end
		attach_req = 4'h5;
		settle();
		chk("phy", 8'h05, ss_phy_on);
		legacy_board = 1'b1;
		settle();
		chk("phy_legacy", 8'h0f, ss_phy_on);
		port_power_wanted = 7'h2a;
		port_status.host_port_off = 7'h08;
		fault = 8'h04;
		settle();
		chk("power", 8'h22, port_power_ctl_oe_n[7:1]);
		chk("overcurrent", 8'h04, port_overcurrent);
		fault = 8'h00;
		port_status.host_port_off = 7'h00;
		ganged_mode = 1'b1;
		settle();
		chk("gang_off", 8'h00, port_power_ctl_oe_n[7:1]);
		common_port_power_ctl = 1'b1;
		settle();
		chk("gang_on", 8'h7f, port_power_ctl_oe_n[7:1]);
		usb2_suspend = 1'b1;
		rom_cs_run_n = 1'b0;
		power_down = 1'b1;
		settle();
		chk("suspend", 8'h01, suspend_flag);
		chk("rom_cs_pd", 8'h01, rom_cs_n);
		power_down = 1'b0;
		settle();
		chk("rom_cs", 8'h00, rom_cs_n);
		utility_config_one_rom_off = 1'b1;
		general_io_four_out = 1'b1;
		general_io_four_oe_n = 1'b0;
		rom_clk_run = 1'b1;
		settle();
		chk("gpio_drive", 8'h02, {rom_clk, rom_clk_oe_n});
		chk("gpio_in", 8'h01, general_io_four_in);
		chk("ctl_out", 8'h00, port_power_ctl_out);
		general_io_four_oe_n = 1'b1;
		settle();
		chk("gpio_release", 8'h01, rom_clk_oe_n);
		utility_config_one_rom_off = 1'b0;
		pin_reset('{MODE_CHARGE_IND, PORTS_NONE, PORTS_NONE, CNT_NONE, CNT_TWO});
		chk("charge_oe", 8'h7c, charge_status_flag_oe_n);
		chk("charge", 8'h02, charge_status_flag & 7'h03);
		por_n = 1'b0;
		strap_pins = '{MODE_SPEED_NO_MGMT, 7'h03, 7'h01, CNT_ONE, CNT_NONE};
		settle();
		chk("por_reset", 8'h01, in_reset);
		chk("por_rom_clk", 8'h00, {rom_clk, rom_clk_oe_n});
		por_n = 1'b1;
		settle();
		chk("por_straps", 8'h01, port_disabled);
		chk("por_fixed", 8'h01, port_fixed);
		report_and_stop();
	end
endmodule

// [tb/hub_sideband_props.sv]
// Port checks of the sideband pin block
`timescale 1ns/100ps
module hub_sideband_props
	import hub_sideband_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic reset_pin_n,
	input wire logic role_swap_cmd,
	input wire logic [3:0] type_c_attach,
	input wire strap_s strap_pins,
	input wire port_status_s port_status,
	input wire logic utility_config_one_rom_off,
	input wire logic power_down,
	input wire logic role_swap_state,
	input wire logic [7:0] port_power_ctl_oe_n,
	input wire logic [3:0] ss_phy_on,
	input wire logic [6:0] link_speed_flag,
	input wire logic [6:0] link_speed_flag_oe_n,
	input wire logic [6:0] charge_status_flag,
	input wire logic [6:0] charge_status_flag_oe_n,
	input wire logic rom_cs_n,
	input wire logic rom_clk,
	input wire logic rom_clk_oe_n,
	input wire logic in_reset,
	input wire logic mgmt_enable,
	input wire logic mgmt_target,
	input wire logic [6:0] port_disabled,
	input wire logic [6:0] port_fixed,
	input wire logic [6:0] port_charge_en
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////
	// Settled pins against level outputs
	a_swap_follow:
	assert property ((!in_reset && $stable(role_swap_cmd))[*6]
		|-> role_swap_state == role_swap_cmd) else $error("swap state");
	a_phy_follow:
	assert property ((!in_reset && $stable(type_c_attach))[*6]
		|-> ss_phy_on == type_c_attach) else $error("phy power");
	a_speed_drive:
	assert property ($stable(port_status)[*6] |->
		((link_speed_flag ^ port_status.superspeed) & ~link_speed_flag_oe_n) == 7'h00
		&& (~port_status.connected & ~link_speed_flag_oe_n) == 7'h00)
		else $error("speed flag");
	a_charge_drive:
	assert property ($stable(port_status)[*6] |->
		((charge_status_flag ^ ~port_status.bc_handshake)
		& ~charge_status_flag_oe_n) == 7'h00
		&& (~port_charge_en & ~charge_status_flag_oe_n) == 7'h00)
		else $error("charge flag");
	a_rom_cs_down:
	assert property ((power_down && !utility_config_one_rom_off)[*6]
		|-> rom_cs_n) else $error("rom select in power down");
	a_rom_clk_low:
	assert property (in_reset && $past(in_reset) && !utility_config_one_rom_off
		&& !$past(utility_config_one_rom_off) |-> !rom_clk && !rom_clk_oe_n)
		else $error("rom clock in reset");
	a_port_off:
	assert property ($fell(in_reset) |-> ##2
		port_disabled == (strap_pins.dp_off & strap_pins.dm_off))
		else $error("port disable decode");
	a_straps_held:
	assert property ((!in_reset)[*4] |->
		$stable({port_disabled, port_fixed, port_charge_en}))
		else $error("captured straps moved");
	a_mgmt_target:
	assert property (mgmt_enable |-> mgmt_target) else $error("mgmt role");
	a_reset_enter:
	assert property ((!reset_pin_n)[*7] |-> in_reset) else $error("reset mode");
	a_off_drive:
	assert property ((!in_reset)[*4] |->
		(port_disabled & port_power_ctl_oe_n[7:1]) == 7'h00)
		else $error("disabled port released");
	// Main scenarios reached
	c_swapped: cover property (role_swap_state && !in_reset);
	c_charge: cover property (charge_status_flag_oe_n != 7'h7f);
	c_rom_pd: cover property (power_down && rom_cs_n && !in_reset);
endmodule

bind hub_sideband_ctl hub_sideband_props u_props (.*);
